// >>> tb/watchdog_timer_tb.sv
/*
 * Self-checking bench for the watchdog / interval timer top.
 * Assumes the top acks each classic Wishbone request after one wait
 * state and that osc_i is sampled on clk_i.
 */
module watchdog_timer_tb
    import wd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk_i;
    logic              rst_i;
    logic              wb_cyc_i;
    logic              wb_stb_i;
    logic              wb_we_i;
    logic [ADDR_W-1:0] wb_adr_i;
    logic [3:0]        wb_sel_i;
    logic [DATA_W-1:0] wb_dat_i;
    logic [DATA_W-1:0] wb_dat_o;
    logic              wb_ack_o;
    logic              osc_i;
    logic              irq_o;
    logic              wdt_reset_o;
    logic              osc_on;
    int                miscompares;
    int                checks;
    int                cyc_n;
    int                pulses;
    // Behavioural model of the register file
    logic [7:0]        m_cnt;
    logic [3:0]        m_sel;
    logic [7:0]        m_ctrl;
    logic [1:0]        m_stat;
    logic [1:0]        m_mask;
    logic              m_armed;
    logic [31:0]       q;
    logic [31:0]       rnd;

    watchdog_timer dut (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .wb_cyc_i    (wb_cyc_i),
        .wb_stb_i    (wb_stb_i),
        .wb_we_i     (wb_we_i),
        .wb_adr_i    (wb_adr_i),
        .wb_sel_i    (wb_sel_i),
        .wb_dat_i    (wb_dat_i),
        .wb_dat_o    (wb_dat_o),
        .wb_ack_o    (wb_ack_o),
        .osc_i       (osc_i),
        .irq_o       (irq_o),
        .wdt_reset_o (wdt_reset_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Fastest legal oscillator: a rising edge every second cycle
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        osc_i <= osc_on ? ~osc_i : 1'b0;
        if (wdt_reset_o === 1'b1)
            pulses <= pulses + 1;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic bus(input logic we, input logic [15:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        // Only the watchdog process bounds this wait
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d,
                      input logic [3:0] s = 4'hf);
        bus(1'b1, a, {24'h0, d}, s);
        if (s[0]) begin
            case (a)
                COUNT_OFS: if (m_ctrl[6]) m_cnt = d;
                CLKSRC_OFS: m_sel = d[3:0];
                CTRL_OFS: begin
                    if (m_armed && !d[7]) m_ctrl[7] = 1'b0;
                    m_armed = 1'b0;
                    m_ctrl[6:0] = d[6:0] & 7'h64;
                end
                IRQ_STAT_OFS: m_stat = m_stat & ~d[1:0];
                IRQ_MASK_OFS: m_mask = d[1:0];
                default: ;
            endcase
        end
    endtask

    function automatic logic [31:0] model_rd(input logic [15:0] a);
        case (a)
            COUNT_OFS:    return {24'h0, m_cnt};
            CLKSRC_OFS:   return {24'h0, CLKSRC_RSV, m_sel};
            CTRL_OFS:     return {24'h0, m_ctrl};
            IRQ_STAT_OFS: return {30'h0, m_stat};
            IRQ_MASK_OFS: return {30'h0, m_mask};
            default:      return 32'h0;
        endcase
    endfunction

    task automatic rd(input logic [15:0] a);
        bus(1'b0, a, 32'h0, 4'hf);
        check($sformatf("reg %h", a), q, model_rd(a));
        if (a == CTRL_OFS && m_ctrl[7]) m_armed = 1'b1;
    endtask

    // Spacing of two observed count steps, read granularity 3 cycles
    task automatic measure(input int p);
        logic [7:0] c0;
        int t1;
        int n;
        bus(1'b0, COUNT_OFS, 32'h0, 4'hf);
        c0 = q[7:0];
        for (int e = 0; e < 2; e++) begin
            n = 0;
            do begin
                bus(1'b0, COUNT_OFS, 32'h0, 4'hf);
                n++;
            end while (q[7:0] === c0 && n < p);
            check("count step", {24'h0, q[7:0]}, c0 + 8'h1);
            c0 = q[7:0];
            if (e == 0) t1 = cyc_n;
        end
        check("tick period", (cyc_n - t1 >= p - 4) && (cyc_n - t1 <= p + 4),
              1);
    endtask

    initial begin
        repeat (90000) @(posedge clk_i);
        miscompares++;
        results();
    end

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, osc_on, osc_i} = 5'h0;
        wb_adr_i = 16'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        {miscompares, checks, cyc_n, pulses} = '0;
        {m_cnt, m_ctrl, m_stat, m_mask, m_armed} = '0;
        m_sel = CLKSRC_RST;
        rnd = $urandom(32'he0f2);
        rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        // All five registers, then one unmapped word
        for (int i = 0; i < 6; i++)
            rd(COUNT_OFS + 16'(4 * i));
        $display("test reset done");

        rnd = $urandom();
        wr(CLKSRC_OFS, 8'h08);
        wr(COUNT_OFS, rnd[7:0]);
        rd(COUNT_OFS);
        wr(CTRL_OFS, 8'h40);
        wr(COUNT_OFS, rnd[15:8], 4'he);
        wr(COUNT_OFS, rnd[23:16]);
        wr(16'hffc4, rnd[7:0]);
        repeat (300) @(posedge clk_i);
        rd(COUNT_OFS);
        wr(CLKSRC_OFS, {rnd[31:28], rnd[27:24]});
        rd(CLKSRC_OFS);
        $display("test write permit done");

        for (int s = 8; s < 17; s++) begin
            rnd = $urandom();
            osc_on <= (s == 16);
            wr(CTRL_OFS, 8'h40);
            wr(COUNT_OFS, 8'h00);
            // Oscillator only chosen with the watchdog function
            wr(CLKSRC_OFS, (s == 16) ? {5'h0, rnd[2:0]}
                                     : s[7:0]);
            wr(CTRL_OFS, 8'h44);
            measure((s == 16) ? 4096 : 64 << (s - 8));
        end
        osc_on <= 1'b0;
        wr(CTRL_OFS, 8'h40);
        $display("test clock select done");

        for (int f = 0; f < 2; f++) begin
            wr(CTRL_OFS, 8'h40 | (f << 5));
            wr(CLKSRC_OFS, 8'h08);
            wr(COUNT_OFS, 8'hff);
            wr(IRQ_MASK_OFS, 8'h03);
            pulses = 0;
            wr(CTRL_OFS, 8'h44 | (f << 5));
            for (int n = 0; n < 200 && irq_o !== 1'b1; n++)
                @(posedge clk_i);
            repeat (3) @(posedge clk_i);
            wr(CTRL_OFS, 8'h40 | (f << 5));
            m_cnt = 8'h00;
            m_ctrl[7] = 1'b1;
            m_stat[f ? IRQ_ROLL_BIT : IRQ_WDOG_BIT] = 1'b1;
            check("reset pulses", pulses, f ? 0 : 1);
            rd(COUNT_OFS);
            rd(IRQ_STAT_OFS);
            check("irq on", irq_o, |(m_stat & m_mask));
            wr(IRQ_MASK_OFS, 8'h00);
            // Mask lands at the ack edge; look once it has settled
            @(posedge clk_i);
            check("irq masked", irq_o, |(m_stat & m_mask));
            rd(CTRL_OFS);
            wr(CTRL_OFS, 8'hc0 | (f << 5));
            wr(CTRL_OFS, 8'h40 | (f << 5));
            rd(CTRL_OFS);
            wr(CTRL_OFS, 8'h40 | (f << 5));
            rd(CTRL_OFS);
            wr(IRQ_STAT_OFS, 8'h03);
            rd(IRQ_STAT_OFS);
        end
        $display("test rollover done");
        results();
    end
endmodule

// >>> verilog/count_clock_select.sv
/*
 * Count clock selector: one free-running system clock prescaler and
 * an oscillator edge divider, reduced to a single-cycle tick.
 * Assumes osc_i is a level synchronous to clk_i.
 */
module count_clock_select
    import wd_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  osc_i,
    wd_core_if.presc   core
);

    logic [PRESC_W-1:0]   presc_ff;
    logic [PRESC_W-1:0]   div_mask;
    logic                 sys_tick;
    logic                 osc_q_ff;
    logic                 osc_rise;
    logic [OSC_DIV_W-1:0] osc_cnt_ff;
    logic                 osc_tick;

    // One prescaler for all system clock divisions keeps ticks phase aligned
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc_ff <= '0;
        end else begin
            presc_ff <= presc_ff + 1'b1;
        end
    end

    always_comb begin
        div_mask = PRESC_W'((1 << (SYS_DIV_LOG2_MIN
                   + 32'(core.clk_sel[2:0]))) - 1);
    end

    // Pulse when the selected low bits are all ones
    assign sys_tick = (presc_ff & div_mask) == div_mask;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_q_ff <= 1'b0;
        end else begin
            osc_q_ff <= osc_i;
        end
    end

    assign osc_rise = osc_i & ~osc_q_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_cnt_ff <= '0;
        end else if (osc_rise) begin
            osc_cnt_ff <= osc_cnt_ff + 1'b1;
        end
    end

    assign osc_tick  = osc_rise & (osc_cnt_ff == OSC_LAST);
    // Top bit low ignores the low three bits
    assign core.tick = core.clk_sel[SEL_SYS_BIT] ? sys_tick
                                                 : osc_tick;

    // Helper: cycles since the last tick with a stable select
    logic [PRESC_W:0]   gap_ff;
    logic [SEL_W-1:0]   sel_q_ff;
    logic               valid_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_ff   <= '0;
            sel_q_ff <= CLKSRC_RST;
            valid_ff <= 1'b0;
        end else begin
            gap_ff   <= core.tick ? '0 : gap_ff + 1'b1;
            sel_q_ff <= core.clk_sel;
            if (sel_q_ff != core.clk_sel) begin
                valid_ff <= 1'b0;
            end else if (core.tick) begin
                valid_ff <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_SYS_DIV_LOW: assert property (
        core.tick && valid_ff && sel_q_ff == core.clk_sel
        && core.clk_sel[3:2] == 2'h2
        |-> gap_ff == (PRESC_W+1)'((64 << core.clk_sel[1:0]) - 1))
        else $error("low system division period wrong");

    AST_SYS_DIV_HIGH: assert property (
        core.tick && valid_ff && sel_q_ff == core.clk_sel
        && core.clk_sel[3:2] == 2'h3
        |-> gap_ff == (PRESC_W+1)'((1024 << core.clk_sel[1:0]) - 1))
        else $error("high system division period wrong");

    AST_OSC_DIV: assert property (
        !core.clk_sel[SEL_SYS_BIT] && core.tick
        |-> osc_rise && osc_cnt_ff == OSC_LAST ##1 osc_cnt_ff == 11'h0)
        else $error("oscillator tick not on 2048th edge");

    AST_TICK_PULSE: assert property (
        core.clk_sel[SEL_SYS_BIT] && $stable(core.clk_sel) && core.tick
        |=> !core.tick)
        else $error("system tick longer than one cycle");

endmodule

// >>> verilog/watchdog_timer.sv
/*
 * Watchdog / interval timer top: Wishbone register slave, control
 * bits, rollover flag, interrupt status and mask, reset request.
 * Assumes a classic Wishbone master on clk_i and an on-chip
 * oscillator level on osc_i synchronous to clk_i.
 */
// Contract
// - 8-bit counter, readable, writable, advances per tick.
// - Clock source upper four bits read ones.
// - Codes 1000-1011 count system clock /64../512.
// - Codes 1100-1111 count system clock /1024../8192.
// - Top bit zero: oscillator divided by 2048.
// - Rollover sets flag; read one, write zero.
// - Function bit: 0 watchdog, 1 interval.
// - Counts while run bit set, else holds.
// - Counter writes only with write permit set.
module watchdog_timer
    import wd_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [DATA_W-1:0] wb_dat_i,
    output logic      [DATA_W-1:0] wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              osc_i,
    output logic                   irq_o,
    output logic                   wdt_reset_o
);

    wd_core_if core ();

    logic              req;
    logic              ack_ff;
    logic              wr_do;
    logic              rd_do;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] rdata_ff;
    logic              hit_cnt;
    logic              hit_src;
    logic              hit_ctrl;
    logic              hit_stat;
    logic              hit_mask;

    logic [SEL_W-1:0]  clksrc_ff;
    logic              permit_ff;
    logic              run_ff;
    timer_func_t       func_ff;
    logic              flag_ff;
    logic              nxt_flag;
    logic              armed_ff;
    logic [IRQ_W-1:0]  stat_ff;
    logic [IRQ_W-1:0]  nxt_stat;
    logic [IRQ_W-1:0]  mask_ff;
    logic [IRQ_W-1:0]  events;
    logic              wdt_rst_ff;
    logic [7:0]        ctrl_rd;
    logic [7:0]        wbyte;

    count_clock_select u_clk_sel (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .osc_i (osc_i),
        .core  (core.presc)
    );

    wd_up_counter u_counter (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .core  (core.cntr)
    );

    // Bus slave: one wait state, ack for exactly one cycle
    assign req   = wb_cyc_i & wb_stb_i;
    assign wbyte = wb_dat_i[7:0];
    assign wr_do = req & ack_ff & wb_we_i & wb_sel_i[0];
    assign rd_do = req & ack_ff & ~wb_we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    assign wb_ack_o = ack_ff;

    assign hit_cnt  = wb_adr_i == COUNT_OFS;
    assign hit_src  = wb_adr_i == CLKSRC_OFS;
    assign hit_ctrl = wb_adr_i == CTRL_OFS;
    assign hit_stat = wb_adr_i == IRQ_STAT_OFS;
    assign hit_mask = wb_adr_i == IRQ_MASK_OFS;

    always_comb begin
        ctrl_rd                  = 8'h00;
        ctrl_rd[CTRL_FLAG_BIT]   = flag_ff;
        ctrl_rd[CTRL_PERMIT_BIT] = permit_ff;
        ctrl_rd[CTRL_FUNC_BIT]   = func_ff;
        ctrl_rd[CTRL_RUN_BIT]    = run_ff;
    end

    // Unmapped addresses still ack and read as zero
    always_comb begin
        rd_mux = '0;
        case (1'b1)
            hit_cnt: begin
                rd_mux[CNT_W-1:0] = core.count;
            end
            hit_src: begin
                rd_mux[7:0] = {CLKSRC_RSV, clksrc_ff};
            end
            hit_ctrl: begin
                rd_mux[7:0] = ctrl_rd;
            end
            hit_stat: begin
                rd_mux[IRQ_W-1:0] = stat_ff;
            end
            hit_mask: begin
                rd_mux[IRQ_W-1:0] = mask_ff;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // Data sampled when the request arrives, held through the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_ff <= '0;
        end else if (req & ~ack_ff) begin
            rdata_ff <= rd_mux;
        end
    end

    assign wb_dat_o = rdata_ff;

    // Clock source select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clksrc_ff <= CLKSRC_RST;
        end else if (wr_do & hit_src) begin
            // Medium-speed restrictions are left to software
            clksrc_ff <= wbyte[SEL_W-1:0];
        end
    end

    assign core.clk_sel = clksrc_ff;

    // Control bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            permit_ff <= 1'b0;
            run_ff    <= 1'b0;
            func_ff   <= FUNC_RST;
        end else if (wr_do & hit_ctrl) begin
            permit_ff <= wbyte[CTRL_PERMIT_BIT];
            run_ff    <= wbyte[CTRL_RUN_BIT];
            func_ff   <= timer_func_t'(wbyte[CTRL_FUNC_BIT]);
        end
    end

    assign core.run      = run_ff;
    assign core.load     = wr_do & hit_cnt & permit_ff;
    assign core.load_val = wbyte[CNT_W-1:0];

    // Clearing needs a read that returned one; a stray zero write
    // cannot wipe an overflow that software never saw
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            armed_ff <= 1'b0;
        end else if (rd_do & hit_ctrl) begin
            armed_ff <= rdata_ff[CTRL_FLAG_BIT];
        end else if ((wr_do & hit_ctrl) | ~flag_ff) begin
            armed_ff <= 1'b0;
        end
    end

    // A rollover in the clearing cycle wins
    always_comb begin
        nxt_flag = flag_ff;
        if (core.wrap) begin
            nxt_flag = 1'b1;
        end else if (wr_do & hit_ctrl & armed_ff
                     & ~wbyte[CTRL_FLAG_BIT]) begin
            nxt_flag = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    // Function decides what a rollover raises
    always_comb begin
        events               = '0;
        events[IRQ_ROLL_BIT] = core.wrap & (func_ff == FUNC_INTERVAL);
        events[IRQ_WDOG_BIT] = core.wrap & (func_ff == FUNC_WATCHDOG);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_rst_ff <= 1'b0;
        end else begin
            wdt_rst_ff <= events[IRQ_WDOG_BIT];
        end
    end

    assign wdt_reset_o = wdt_rst_ff;

    // Sticky status, write one to clear, set wins
    always_comb begin
        nxt_stat = stat_ff;
        if (wr_do & hit_stat) begin
            nxt_stat = stat_ff & ~wbyte[IRQ_W-1:0];
        end
        nxt_stat = nxt_stat | events;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_ff <= IRQ_RST;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_ff <= IRQ_RST;
        end else if (wr_do & hit_mask) begin
            mask_ff <= wbyte[IRQ_W-1:0];
        end
    end

    assign irq_o = |(stat_ff & mask_ff);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_ACK_ONE_CYCLE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    AST_RSV_ONES: assert property (
        rd_do && hit_src |-> wb_dat_o[7:4] == 4'hf)
        else $error("reserved select bits not read as ones");

    AST_COUNT_READ: assert property (
        req && !ack_ff && hit_cnt
        |=> wb_dat_o[CNT_W-1:0] == $past(core.count))
        else $error("counter read value wrong");

    AST_FLAG_SET: assert property (
        core.wrap |=> flag_ff)
        else $error("rollover did not set flag");

    AST_FLAG_NEEDS_READ: assert property (
        flag_ff && !armed_ff && !core.wrap |=> flag_ff)
        else $error("flag cleared without a prior read");

    AST_FLAG_CLEAR: assert property (
        armed_ff && wr_do && hit_ctrl && !wbyte[CTRL_FLAG_BIT]
        && !core.wrap |=> !flag_ff)
        else $error("read-then-write-zero did not clear flag");

    AST_WDOG_RESET: assert property (
        core.wrap && func_ff == FUNC_WATCHDOG
        |=> wdt_reset_o && stat_ff[IRQ_WDOG_BIT] ##1 !wdt_reset_o)
        else $error("watchdog rollover gave no reset pulse");

    AST_INTERVAL_IRQ: assert property (
        core.wrap && func_ff == FUNC_INTERVAL
        |=> !wdt_reset_o && stat_ff[IRQ_ROLL_BIT])
        else $error("interval rollover handled as watchdog");

    AST_LOAD_PERMIT: assert property (
        wr_do && hit_cnt && !permit_ff && !(run_ff && core.tick)
        |=> $stable(core.count))
        else $error("counter written without permit");

    AST_RUN_GATE: assert property (
        !run_ff |-> !core.wrap)
        else $error("rollover while stopped");

    AST_ACK_WAIT: assert property (
        req && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked after one wait state");

    AST_WDOG_STICKY: assert property (
        stat_ff[IRQ_WDOG_BIT] && !(wr_do && hit_stat) |=> stat_ff[IRQ_WDOG_BIT])
        else $error("watchdog status dropped without a clear");

    AST_ROLL_STICKY: assert property (
        stat_ff[IRQ_ROLL_BIT] && !(wr_do && hit_stat) |=> stat_ff[IRQ_ROLL_BIT])
        else $error("interval status dropped without a clear");

    AST_WDOG_ONLY_WRAP: assert property (
        !(core.wrap && func_ff == FUNC_WATCHDOG) |=> !wdt_reset_o)
        else $error("reset request without watchdog rollover");

    COV_INTERVAL_IRQ: cover property (
        core.wrap && func_ff == FUNC_INTERVAL ##1 irq_o);

    COV_WDOG_RESET: cover property (
        wdt_reset_o);

    COV_FLAG_CLEARED: cover property (
        flag_ff ##1 armed_ff ##[1:20] !flag_ff);

    COV_PROTECTED_WRITE: cover property (
        wr_do && hit_cnt && !permit_ff);

endmodule

// >>> verilog/wd_core_if.sv
/*
 * Bundle between the timer top, its clock selector and its counter.
 * Assumes all three run on the same clock.
 */
interface wd_core_if;
    import wd_pkg::*;

    logic [SEL_W-1:0] clk_sel;
    logic             tick;
    logic             run;
    logic             load;
    logic [CNT_W-1:0] load_val;
    logic [CNT_W-1:0] count;
    logic             wrap;

    modport ctrl  (output clk_sel, run, load, load_val,
                   input  tick, count, wrap);
    modport presc (input  clk_sel, output tick);
    modport cntr  (input  tick, run, load, load_val,
                   output count, wrap);
endinterface

// >>> verilog/wd_pkg.sv
/*
 * Shared constants for the watchdog / interval timer: register
 * offsets, field positions, reset values and divider sizes.
 * Assumes a 16-bit byte address and 32-bit Wishbone data.
 */
package wd_pkg;

    localparam int unsigned ADDR_W   = 16;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned CNT_W    = 8;
    localparam int unsigned SEL_W    = 4;
    localparam int unsigned IRQ_W    = 2;

    // Register byte addresses
    localparam logic [15:0] COUNT_OFS    = 16'hffb0;
    localparam logic [15:0] CLKSRC_OFS   = 16'hffb4;
    localparam logic [15:0] CTRL_OFS     = 16'hffb8;
    localparam logic [15:0] IRQ_STAT_OFS = 16'hffbc;
    localparam logic [15:0] IRQ_MASK_OFS = 16'hffc0;

    // Reset values
    localparam logic [7:0] CNT_RST    = 8'h00;
    localparam logic [3:0] CLKSRC_RST = 4'hf;
    localparam logic [3:0] CLKSRC_RSV = 4'hf;
    localparam logic [1:0] IRQ_RST    = 2'h0;

    // Control register fields
    localparam int unsigned CTRL_FLAG_BIT   = 7;
    localparam int unsigned CTRL_PERMIT_BIT = 6;
    localparam int unsigned CTRL_FUNC_BIT   = 5;
    localparam int unsigned CTRL_RUN_BIT    = 2;

    // Interrupt status / mask fields
    localparam int unsigned IRQ_ROLL_BIT = 0;
    localparam int unsigned IRQ_WDOG_BIT = 1;

    // Clock select field
    localparam int unsigned SEL_SYS_BIT = 3;

    // Dividers
    localparam int unsigned PRESC_W          = 13;
    localparam int unsigned SYS_DIV_LOG2_MIN = 6;
    localparam int unsigned OSC_DIV_W        = 11;
    localparam logic [10:0] OSC_LAST         = 11'h7ff;

    typedef enum logic {
        FUNC_WATCHDOG = 1'b0,
        FUNC_INTERVAL = 1'b1
    } timer_func_t;

    localparam timer_func_t FUNC_RST = FUNC_WATCHDOG;

endpackage

// >>> verilog/wd_up_counter.sv
/*
 * Eight-bit up-counter with load, run gate and rollover pulse.
 * Assumes load is already qualified by the write permit.
 */
module wd_up_counter
    import wd_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    wd_core_if.cntr    core
);

    logic [CNT_W-1:0] count_ff;
    logic             step;

    assign step = core.run & core.tick & ~core.load;

    // Software load wins over a tick in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_ff <= CNT_RST;
        end else if (core.load) begin
            count_ff <= core.load_val;
        end else if (step) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    assign core.count = count_ff;
    assign core.wrap  = step & (&count_ff);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_COUNT_ADVANCE: assert property (
        step |=> core.count == $past(core.count) + 8'h1)
        else $error("counter did not advance on tick");

    AST_COUNT_HOLD: assert property (
        !core.run && !core.load |=> $stable(core.count))
        else $error("counter moved while stopped");

    AST_COUNT_LOAD: assert property (
        core.load |=> core.count == $past(core.load_val))
        else $error("counter load lost");

endmodule
